// ### verilog/sil_status_top.sv
`timescale 1ns/1ps
module sil_status_top #(
    parameter int TICK_CYCLES = sil_pkg::TICK_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_good,
    input wire logic dhcp_waiting,
    input wire logic remote_ready,
    input wire logic remote_connected,
    input wire logic [sil_pkg::CHANNELS-1:0] can_err_passive,
    input wire logic [sil_pkg::CHANNELS-1:0] can_bus_off,
    input wire logic [sil_pkg::CHANNELS-1:0] can_err_frame,
    input wire logic reset_button_n,
    input wire sil_pkg::sil_addon_type [sil_pkg::MAX_ADDONS-1:0] addon_slot,
    output logic power_ok_lamp,
    output logic network_state_lamp,
    output wire logic [sil_pkg::CHANNELS-1:0] can_red_lamp,
    output wire logic [sil_pkg::CHANNELS-1:0] can_yellow_lamp,
    output logic [sil_pkg::MAX_ADDONS-1:0][sil_pkg::PIN_W-1:0] addon_first_pin,
    output logic [sil_pkg::MAX_ADDONS-1:0] addon_active,
    output logic [sil_pkg::PIN_W-1:0] addon_pin_total,
    output logic outputs_clear,
    output logic module_reset,
    output logic factory_reset
);
    import sil_pkg::*;

    logic [2:0] rst_pipe;
    logic rst_sync_n;
    logic tick;
    logic fast_phase;
    logic slow_phase;
    logic slower_phase;
    logic btn_stable;
    logic [MS_W-1:0] deb_cnt;
    logic [MS_W-1:0] hold_cnt;
    sil_button_state_type btn_state;
    sil_addon_type [MAX_ADDONS-1:0] layout_seen;
    logic [MAX_ADDONS-1:0][PIN_W-1:0] next_first_pin;
    logic [MAX_ADDONS-1:0] next_active;
    logic [PIN_W-1:0] next_pin_total;
    logic gap_seen;

    // reset release through two flip-flops; a third stage keeps the checks off a cycle longer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe <= 3'h0;
        else
            rst_pipe <= {rst_pipe[1:0], 1'b1};
    end
    assign rst_sync_n = rst_pipe[1];

    sil_blink_if blink ();

    sil_blinker #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_blinker (
        .clock(clock),
        .rst_n(rst_sync_n),
        .blink(blink)
    );

    assign tick = blink.tick;
    assign fast_phase = blink.phase[RATE_FAST];
    assign slow_phase = blink.phase[RATE_SLOW];
    assign slower_phase = blink.phase[RATE_SLOWER];

    // power lamp
    // steady when working
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            power_ok_lamp <= 1'b0;
        else
            power_ok_lamp <= power_good && rst_sync_n;
    end

    // network lamp, connection outranks lease wait and readiness
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            network_state_lamp <= 1'b0;
        else if (remote_connected)
            network_state_lamp <= 1'b1;
        else if (dhcp_waiting)
            network_state_lamp <= fast_phase;
        else if (remote_ready)
            network_state_lamp <= slow_phase;
        else
            network_state_lamp <= 1'b0;
    end

    // button debounce, a change must hold for the whole window
    // debounced press level
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            btn_stable <= 1'b0;
            deb_cnt <= '0;
        end
        else if (!reset_button_n == btn_stable)
            deb_cnt <= '0;
        else if (tick)
        begin
            if (deb_cnt == MS_W'(DEBOUNCE_MS - 1))
            begin
                btn_stable <= !reset_button_n;
                deb_cnt <= '0;
            end
            else
                deb_cnt <= deb_cnt + 1'b1;
        end
    end

    // hold timer; the reset kind is chosen only on release
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            btn_state <= BTN_RELEASED;
            hold_cnt <= '0;
            module_reset <= 1'b0;
            factory_reset <= 1'b0;
        end
        else
        begin
            module_reset <= 1'b0;
            factory_reset <= 1'b0;
            unique case (btn_state)
                BTN_RELEASED:
                begin
                    hold_cnt <= '0;
                    if (btn_stable)
                        btn_state <= BTN_SHORT_HOLD;
                end
                BTN_SHORT_HOLD:
                begin
                    if (!btn_stable)
                    begin
                        module_reset <= 1'b1;
                        btn_state <= BTN_RELEASED;
                    end
                    else if (tick)
                    begin
                        if (hold_cnt == MS_W'(LONG_HOLD_MS - 1))
                            btn_state <= BTN_LONG_HOLD;
                        else
                            hold_cnt <= hold_cnt + 1'b1;
                    end
                end
                BTN_LONG_HOLD:
                begin
                    if (!btn_stable)
                    begin
                        module_reset <= 1'b1;
                        factory_reset <= 1'b1;
                        btn_state <= BTN_RELEASED;
                    end
                end
                default:
                    btn_state <= BTN_RELEASED;
            endcase
        end
    end

    // channel lamps, one copy per CAN channel
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_chan
        logic [MS_W-1:0] flash_cnt;
        logic red;
        logic yellow;
        logic btn_red;

        // button indication owns the red of channels one and two
        // press lights red
        if (c == 0)
        begin : g_btn1
            assign btn_red = (btn_state != BTN_RELEASED);
        end
        else if (c == 1)
        begin : g_btn2
            assign btn_red = (btn_state == BTN_LONG_HOLD);
        end
        else
        begin : g_nobtn
            assign btn_red = 1'b0;
        end

        // short red flash after each error frame, except on a channel that is bus off
        // error frame flash
        always_ff @(posedge clock or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
                flash_cnt <= '0;
            else if (can_err_frame[c])
                flash_cnt <= MS_W'(FLASH_MS);
            else if (tick && flash_cnt != '0)
                flash_cnt <= flash_cnt - 1'b1;
        end

        // bus off outranks error passive
        always_ff @(posedge clock or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
            begin
                red <= 1'b0;
                yellow <= 1'b0;
            end
            else if (btn_red)
            begin
                red <= 1'b1;
                yellow <= 1'b0;
            end
            else if (can_bus_off[c])
            begin
                red <= slower_phase;
                yellow <= slow_phase;
            end
            else if (can_err_passive[c])
            begin
                red <= slow_phase || (flash_cnt != '0);
                yellow <= slow_phase;
            end
            else
            begin
                red <= (flash_cnt != '0);
                yellow <= 1'b0;
            end
        end

        assign can_red_lamp[c] = red;
        assign can_yellow_lamp[c] = yellow;
    end

    // first pin of each slot; slots right of an empty one are ignored
    // four slots only
    always_comb
    begin
        next_pin_total = PIN_FIRST;
        gap_seen = 1'b0;
        next_first_pin = '0;
        next_active = '0;
        for (int i = 0; i < MAX_ADDONS; i++)
        begin
            if (addon_slot[i] == ADDON_NONE)
                gap_seen = 1'b1;
            next_first_pin[i] = next_pin_total;
            next_active[i] = !gap_seen;
            if (!gap_seen)
                next_pin_total = next_pin_total + addon_pins(addon_slot[i]);
        end
    end

    // any layout change renumbers and pulses the output clear
    // renumber and clear
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            layout_seen <= '{default: ADDON_NONE};
            addon_first_pin <= '0;
            addon_active <= '0;
            addon_pin_total <= PIN_FIRST;
            outputs_clear <= 1'b0;
        end
        else
        begin
            layout_seen <= addon_slot;
            outputs_clear <= (addon_slot != layout_seen);
            if (addon_slot != layout_seen)
            begin
                addon_first_pin <= next_first_pin;
                addon_active <= next_active;
                addon_pin_total <= next_pin_total;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_pipe[2]);

    a_power_lamp_on: assert property (power_good |=> power_ok_lamp)
        else $error("power lamp not lit");
    a_net_lease_flash: assert property (
        (dhcp_waiting && !remote_connected) |=> network_state_lamp == $past(fast_phase))
        else $error("lease flash wrong");
    a_net_ready_flash: assert property (
        (remote_ready && !dhcp_waiting && !remote_connected)
        |=> network_state_lamp == $past(slow_phase))
        else $error("ready flash wrong");
    a_net_connected_on: assert property (
        remote_connected [*2] |-> network_state_lamp [*2])
        else $error("connected lamp not steady");
    a_passive_both_blink: assert property (
        (can_err_passive[3] && !can_bus_off[3])
        |=> can_yellow_lamp[3] == $past(slow_phase) && (can_red_lamp[3] || !$past(slow_phase)))
        else $error("passive blink wrong");
    a_error_frame_flash: assert property (
        (can_err_frame[2] && !can_bus_off[2]) ##1 !can_bus_off[2] |=> can_red_lamp[2])
        else $error("error frame flash missing");
    a_busoff_slower_blink: assert property (
        (can_bus_off[1] && btn_state != BTN_LONG_HOLD) |=> can_red_lamp[1] == $past(slower_phase))
        else $error("bus off blink wrong");
    a_first_pins_chain: assert property (
        $rose(outputs_clear) |-> addon_first_pin[0] == PIN_FIRST
        && addon_first_pin[1] == (addon_active[0] ? addon_pins(layout_seen[0]) : PIN_FIRST))
        else $error("pin numbering wrong");
    a_layout_clear_pulse: assert property (
        (addon_slot != layout_seen) |=> outputs_clear && addon_pin_total == $past(next_pin_total))
        else $error("layout change not handled");
    a_press_red_one: assert property (
        $rose(btn_stable) |-> ##2 can_red_lamp[0])
        else $error("press not shown on channel one");
    a_short_release_kind: assert property (
        (btn_state == BTN_SHORT_HOLD && !btn_stable)
        |=> module_reset && !factory_reset && !can_red_lamp[1])
        else $error("short release wrong");
    a_long_release_kind: assert property (
        (btn_state == BTN_LONG_HOLD && !btn_stable)
        |=> module_reset && factory_reset ##1 !module_reset)
        else $error("long release wrong");
    a_reset_only_release: assert property (
        btn_stable |=> !module_reset && !factory_reset)
        else $error("reset issued while held");

    c_long_release: cover property (btn_state == BTN_LONG_HOLD ##1 factory_reset);
    c_short_release: cover property (btn_state == BTN_SHORT_HOLD ##1 module_reset);
    c_lease_wait: cover property (dhcp_waiting && $rose(network_state_lamp));
    c_relayout: cover property (outputs_clear && addon_active[1]);

endmodule : sil_status_top

// ### include/sil_pkg.sv
package sil_pkg;

    // system clock and the millisecond tick derived from it
    localparam int CLK_NS = 5;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;

    // all lamp and button timing is counted in millisecond ticks
    localparam int MS_W = 12;
    localparam int FAST_HALF_MS = 100;
    localparam int SLOW_HALF_MS = 500;
    localparam int SLOWER_HALF_MS = 1000;
    localparam int FLASH_MS = 50;
    localparam int DEBOUNCE_MS = 20;
    localparam int LONG_HOLD_MS = 3000;

    // blink rate indices into the phase vector
    localparam int RATE_FAST = 0;
    localparam int RATE_SLOW = 1;
    localparam int RATE_SLOWER = 2;
    localparam int RATE_COUNT = 3;
    localparam logic [MS_W-1:0] HALF_MS [RATE_COUNT] = '{
        MS_W'(FAST_HALF_MS), MS_W'(SLOW_HALF_MS), MS_W'(SLOWER_HALF_MS)};

    // channels, add-on slots and pin numbering
    localparam int CHANNELS = 4;
    localparam int MAX_ADDONS = 4;
    localparam int PIN_W = 8;
    localparam logic [PIN_W-1:0] PIN_FIRST = 8'h00;
    localparam logic [PIN_W-1:0] DIGITAL_PINS = 8'h20;
    localparam logic [PIN_W-1:0] ANALOG_PINS = 8'h08;
    localparam logic [PIN_W-1:0] RELAY_PINS = 8'h10;

    typedef enum logic [1:0] {
        ADDON_NONE,
        ADDON_DIGITAL,
        ADDON_ANALOG,
        ADDON_RELAY
    } sil_addon_type;

    typedef enum logic [1:0] {
        BTN_RELEASED,
        BTN_SHORT_HOLD,
        BTN_LONG_HOLD
    } sil_button_state_type;

    // number of I/O pins an add-on of the given kind carries
    function automatic logic [PIN_W-1:0] addon_pins(sil_addon_type kind);
        unique case (kind)
            ADDON_DIGITAL: addon_pins = DIGITAL_PINS;
            ADDON_ANALOG: addon_pins = ANALOG_PINS;
            ADDON_RELAY: addon_pins = RELAY_PINS;
            ADDON_NONE: addon_pins = PIN_FIRST;
        endcase
    endfunction : addon_pins

endpackage : sil_pkg

// ### include/sil_blink_if.sv
`timescale 1ns/1ps
// millisecond tick and free-running blink phases
interface sil_blink_if;
    logic tick;
    logic [sil_pkg::RATE_COUNT-1:0] phase;
    modport src (output tick, output phase);
    modport snk (input tick, input phase);
endinterface : sil_blink_if

// ### verilog/sil_blinker.sv
`timescale 1ns/1ps
module sil_blinker #(
    parameter int TICK_CYCLES = sil_pkg::TICK_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    sil_blink_if.src blink
);
    import sil_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES);

    logic [DIV_W-1:0] div;
    logic tick;
    logic [RATE_COUNT-1:0] phase;

    // millisecond enable pulse from the clock divider
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div <= '0;
            tick <= 1'b0;
        end
        else if (div == DIV_W'(TICK_CYCLES - 1))
        begin
            div <= '0;
            tick <= 1'b1;
        end
        else
        begin
            div <= div + 1'b1;
            tick <= 1'b0;
        end
    end

    // one square wave per rate, fast strictly quicker than slow
    // configurable blink rates
    for (genvar r = 0; r < RATE_COUNT; r++)
    begin : g_rate
        logic [MS_W-1:0] cnt;
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cnt <= '0;
                phase[r] <= 1'b0;
            end
            else if (tick)
            begin
                if (cnt == HALF_MS[r] - 1'b1)
                begin
                    cnt <= '0;
                    phase[r] <= ~phase[r];
                end
                else
                begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    assign blink.tick = tick;
    assign blink.phase = phase;

endmodule : sil_blinker

// ### tb/sil_partner_model.sv
`timescale 1ns/1ps
// pushbutton with contact chatter, plus the power lamp of one add-on
module sil_partner_model #(
    parameter int CHATTER = 6,
    parameter int FLASH_CYCLES = 400
) (
    input wire logic clock,
    input wire logic press,
    input wire logic link_up,
    output wire logic reset_button_n,
    output wire logic addon_lamp
);
    logic level = 1'b1;
    logic last_press = 1'b0;
    logic lamp = 1'b0;
    int bounce = 0;
    int flash = 0;

    assign reset_button_n = level;
    assign addon_lamp = lamp;

    // contacts chatter for a few cycles after every change, pull-up when open
    always @(posedge clock)
    begin
        if (press != last_press)
        begin
            bounce <= CHATTER;
        end
        else if (bounce > 0)
        begin
            bounce <= bounce - 1;
        end
        last_press <= press;
        level <= (bounce > 0) ? ~level : ~press;
    end

    // add-on lamp
    // steady while the link runs, flashing while it is lost
    always @(posedge clock)
    begin
        flash <= (flash >= FLASH_CYCLES - 1) ? 0 : flash + 1;
        if (link_up)
        begin
            lamp <= 1'b1;
        end
        else if (flash == 0)
        begin
            lamp <= ~lamp;
        end
    end
endmodule : sil_partner_model

// ### tb/test_status_indicator_and_reset_button.sv
`timescale 1ns/1ps
module test_status_indicator_and_reset_button;
    import sil_pkg::*;
    localparam int TICK = 10;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic power_good = 1'b1;
    logic dhcp_waiting = 1'b0;
    logic remote_ready = 1'b0;
    logic remote_connected = 1'b0;
    logic [CHANNELS-1:0] can_err_passive = 4'h0;
    logic [CHANNELS-1:0] can_bus_off = 4'h0;
    logic [CHANNELS-1:0] can_err_frame = 4'h0;
    logic press = 1'b0;
    logic reset_button_n;
    logic addon_lamp;
    sil_addon_type [MAX_ADDONS-1:0] addon_slot;
    logic power_ok_lamp;
    logic network_state_lamp;
    logic [CHANNELS-1:0] can_red_lamp;
    logic [CHANNELS-1:0] can_yellow_lamp;
    logic [MAX_ADDONS-1:0][PIN_W-1:0] addon_first_pin;
    logic [MAX_ADDONS-1:0] addon_active;
    logic [PIN_W-1:0] addon_pin_total;
    logic outputs_clear;
    logic module_reset;
    logic factory_reset;
    logic [7:0] layouts [6] = '{8'h02, 8'h06, 8'h01, 8'h09, 8'h04, 8'hE7};
    int n_fail = 0;
    int tests_run = 0;
    int red0_cnt, red1_cnt, mr_cnt, fr_cnt;

    sil_status_top #(.TICK_CYCLES(TICK)) dut (.clock(clock), .rst_n(rst_n),
        .power_good(power_good), .dhcp_waiting(dhcp_waiting), .remote_ready(remote_ready),
        .remote_connected(remote_connected), .can_err_passive(can_err_passive),
        .can_bus_off(can_bus_off), .can_err_frame(can_err_frame),
        .reset_button_n(reset_button_n), .addon_slot(addon_slot),
        .power_ok_lamp(power_ok_lamp), .network_state_lamp(network_state_lamp),
        .can_red_lamp(can_red_lamp), .can_yellow_lamp(can_yellow_lamp),
        .addon_first_pin(addon_first_pin), .addon_active(addon_active),
        .addon_pin_total(addon_pin_total), .outputs_clear(outputs_clear),
        .module_reset(module_reset), .factory_reset(factory_reset));

    sil_partner_model partner (.clock(clock), .press(press), .link_up(addon_active[0]),
        .reset_button_n(reset_button_n), .addon_lamp(addon_lamp));

    // free-running system clock
    initial
    begin
        forever #2.5 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    // one comparison, reported at once when it misses
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // power lamp follows the power state; add-on lamp flashes while no slot is counted
    task automatic t_power();
        logic lamp_was;
        lamp_was = addon_lamp;
        power_good = 1'b0;
        cyc(3);
        check("power lamp off", power_ok_lamp, 1'b0); // lamp follows power
        power_good = 1'b1;
        cyc(397);
        check("power lamp on", power_ok_lamp, 1'b1); // steady lamp
        check("addon lamp flash", addon_lamp, !lamp_was); // flashes without link
    endtask : t_power

    // every layout change renumbers pins and pulses the clear
    task automatic t_layout();
        int sum;
        logic chain;
        logic [1:0] code;
        for (int i = 0; i < 6; i++)
        begin
            for (int s = 0; s < MAX_ADDONS; s++)
                addon_slot[s] = sil_addon_type'(layouts[i][2*s+:2]);
            cyc(1);
            for (int k = 0; k < 3 && outputs_clear !== 1'b1; k++)
                cyc(1);
            check("clear pulse", outputs_clear, 1'b1); // outputs cleared
            sum = 0;
            chain = 1'b1;
            for (int s = 0; s < MAX_ADDONS; s++)
            begin
                code = layouts[i][2*s+:2];
                chain = chain && (code != 2'h0);
                check("slot active", addon_active[s], chain); // chain
                if (chain)
                begin
                    check("first pin", addon_first_pin[s], sum); // numbering
                    sum += (code == 2'h1) ? DIGITAL_PINS : (code == 2'h2) ? ANALOG_PINS : RELAY_PINS;
                end
            end
            check("pin total", addon_pin_total, sum); // first free pin
            cyc(1);
            check("clear ends", outputs_clear, 1'b0); // single pulse
        end
        check("addon lamp steady", addon_lamp, 1'b1); // steady with link
    endtask : t_layout

    // connected beats lease wait, lease wait flashes fast
    task automatic t_network();
        int hi;
        int n;
        logic last;
        remote_connected = 1'b1;
        dhcp_waiting = 1'b1;
        hi = 0;
        cyc(2);
        repeat (2500)
        begin
            cyc(1);
            if (network_state_lamp === 1'b1)
                hi++;
        end
        check("steady connected", hi, 2500); // steady lamp
        remote_connected = 1'b0;
        // pass the mode change edge, then settle on a true phase edge
        for (int j = 0; j < 2; j++)
        begin
            last = network_state_lamp;
            for (int k = 0; k < 4000 && network_state_lamp === last; k++)
                cyc(1);
        end
        last = network_state_lamp;
        for (n = 0; n < 4000 && network_state_lamp === last; n++)
            cyc(1);
        check("fast half period", n, FAST_HALF_MS * TICK); // fast flash
        dhcp_waiting = 1'b0;
    endtask : t_network

    // one error frame gives a short red flash only
    task automatic t_flash();
        can_err_frame[2] = 1'b1;
        cyc(1);
        can_err_frame[2] = 1'b0;
        cyc((FLASH_MS - 10) * TICK);
        check("flash on", can_red_lamp[2], 1'b1); // short flash
        check("flash no yellow", can_yellow_lamp[2], 1'b0); // red only
        cyc(20 * TICK);
        check("flash over", can_red_lamp[2], 1'b0); // short flash
    endtask : t_flash

    // slow network flash, error passive and bus off half periods together
    task automatic t_blink();
        logic [3:0] now;
        logic [3:0] prev;
        int first [4];
        int gap [4];
        int odd;
        remote_ready = 1'b1;
        can_err_passive[3] = 1'b1;
        can_bus_off[1] = 1'b1;
        odd = 0;
        for (int j = 0; j < 4; j++)
        begin
            first[j] = -1;
            gap[j] = 0;
        end
        cyc(3);
        prev = {can_red_lamp[3], can_yellow_lamp[1], can_red_lamp[1], network_state_lamp};
        for (int k = 1; k <= 2 * SLOWER_HALF_MS * TICK + 20; k++)
        begin
            cyc(1);
            now = {can_red_lamp[3], can_yellow_lamp[1], can_red_lamp[1], network_state_lamp};
            if (can_red_lamp[3] !== can_yellow_lamp[3])
                odd++;
            for (int j = 0; j < 4; j++)
            begin
                if (now[j] !== prev[j] && first[j] < 0)
                    first[j] = k;
                else if (now[j] !== prev[j] && gap[j] == 0)
                    gap[j] = k - first[j];
            end
            prev = now;
        end
        check("slow net", gap[0], SLOW_HALF_MS * TICK); // slow flash
        check("bus off red", gap[1], SLOWER_HALF_MS * TICK); // slower red
        check("bus off yellow", gap[2], SLOW_HALF_MS * TICK); // yellow blinks
        check("passive red", gap[3], SLOW_HALF_MS * TICK); // passive blink
        check("passive pair", odd, 0); // red with yellow
        remote_ready = 1'b0;
        can_err_passive = 4'h0;
        can_bus_off = 4'h0;
        cyc(3);
    endtask : t_blink

    // run cycles while counting button lamps and reset pulses
    task automatic watch(input int n);
        for (int k = 0; k < n; k++)
        begin
            cyc(1);
            red0_cnt += (can_red_lamp[0] === 1'b1);
            red1_cnt += (can_red_lamp[1] === 1'b1);
            mr_cnt += (module_reset === 1'b1);
            fr_cnt += (factory_reset === 1'b1 && module_reset === 1'b1) ? 1 : 0;
        end
    endtask : watch

    task automatic zero_watch();
        red0_cnt = 0;
        red1_cnt = 0;
        mr_cnt = 0;
        fr_cnt = 0;
    endtask : zero_watch

    // a press shorter than the debounce time is ignored
    task automatic t_bounce();
        zero_watch();
        press = 1'b1;
        watch(10 * TICK);
        press = 1'b0;
        watch(60 * TICK);
        check("bounce lamp", red0_cnt, 0); // debounce
        check("bounce reset", mr_cnt, 0); // debounce
    endtask : t_bounce

    // short hold: channel one red, module reset on release
    task automatic t_short();
        zero_watch();
        press = 1'b1;
        watch(30 * TICK);
        check("short red one", can_red_lamp[0], 1'b1); // lit on press
        check("short yellow one", can_yellow_lamp[0], 1'b0); // red shown
        watch(200 * TICK);
        check("short held reset", mr_cnt, 0); // acts on release
        press = 1'b0;
        watch(40 * TICK);
        check("short red two", red1_cnt, 0); // channel one only
        check("short module reset", mr_cnt, 1); // module reset
        check("short factory", fr_cnt, 0); // no factory reset
        check("short lamp off", can_red_lamp[0], 1'b0); // lamp off after release
    endtask : t_short

    // long hold: channel two red too, factory reset on release
    task automatic t_long();
        zero_watch();
        press = 1'b1;
        watch((LONG_HOLD_MS - 100) * TICK);
        check("long early red two", red1_cnt, 0); // three second mark
        watch(200 * TICK);
        check("long red one", can_red_lamp[0], 1'b1); // both lamps
        check("long red two", can_red_lamp[1], 1'b1); // both lamps
        check("long held reset", mr_cnt, 0); // acts on release
        press = 1'b0;
        watch(40 * TICK);
        check("long module reset", mr_cnt, 1); // module reset
        check("long factory", fr_cnt, 1); // factory reset
    endtask : t_long

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // main sequence
    initial
    begin
        for (int s = 0; s < MAX_ADDONS; s++)
            addon_slot[s] = ADDON_NONE;
        cyc(3);
        check("lamp in reset", power_ok_lamp, 1'b0); // dark in reset
        cyc(3);
        rst_n = 1'b1;
        cyc(4);
        t_power();
        t_layout();
        t_network();
        t_flash();
        t_blink();
        t_bounce();
        t_short();
        t_long();
        give_verdict();
    end

    // watchdog against a hung scenario
    initial
    begin
        #450000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : test_status_indicator_and_reset_button
